// ---- rtl/wmx_regs.svh ----
// constants for the extended multi-sector write task file
`ifndef WMX_REGS_SVH
`define WMX_REGS_SVH
`define TF_DATA 3'h0
`define TF_ERRFEAT 3'h1
`define TF_SCOUNT 3'h2
`define TF_SNUM 3'h3
`define TF_CYLLO 3'h4
`define TF_CYLHI 3'h5
`define TF_DEVHEAD 3'h6
`define TF_CMDSTAT 3'h7
`define CMD_WR_MULT_EXT 8'h39
`define CMD_WR_MULT_FUA_EXT 8'hCE
`define ST_BSY 7
`define ST_RDY 6
`define ST_DSC 4
`define ST_DRQ 3
`define ST_ERR 0
`define ER_UNC 6
`define ER_IDN 4
`define ER_ABT 2
`define STATUS_IDLE 8'h50
`define CTL_HOB 7
`define HREG_CTRL 4'h0
`define HREG_STATUS 4'h1
`define HREG_IRQ_STAT 4'h2
`define HREG_IRQ_MASK 4'h3
`define HREG_COUNT 4'h4
`define HREG_LBA_LO 4'h5
`define HREG_LBA_HI 4'h6
`define HREG_WDATA 4'h7
`define HREG_ERRLBA_LO 4'h8
`define HREG_ERRLBA_HI 4'h9
`define HREG_TFSTAT 4'hA
`define IRQ_BLOCK 0
`define IRQ_DONE 1
`endif

// ---- rtl/wmx_pkg.sv ----
// shared types for the extended multi-sector write ends
package wmx_pkg;
   typedef enum logic [2:0] {
      DEV_IDLE = 3'b000,
      DEV_XFER = 3'b001,
      DEV_COMMIT = 3'b010,
      DEV_FLUSH = 3'b011,
      DEV_DONE = 3'b100
   } dev_state_type;
   typedef enum logic [2:0] {
      HST_IDLE = 3'b000,
      HST_SETUP = 3'b001,
      HST_WAIT = 3'b010,
      HST_DATA = 3'b011,
      HST_POLL = 3'b100,
      HST_READ = 3'b101
   } host_state_type;
endpackage

// ---- rtl/task_file_if.sv ----
// task-file link between host adapter and device
`timescale 1ns/1ns
interface task_file_if;
   logic [2:0] addr;
   logic [15:0] wdata;
   logic wr;
   logic rd;
   logic hob;
   logic [15:0] rdata;
   logic intrq;
   modport host (output addr, output wdata, output wr, output rd, output hob, input rdata, input intrq);
   modport device (input addr, input wdata, input wr, input rd, input hob, output rdata, output intrq);
endinterface

// ---- rtl/lba_walker.sv ----
// sector address and remaining-count tracker
`timescale 1ns/1ns
module lba_walker (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic load_in,
   input wire logic [47:0] lba_in,
   input wire logic [15:0] count_in,
   input wire logic step_in,
   output logic [47:0] lba_out,
   output logic [16:0] left_out
);
   typedef struct packed {
      logic [47:0] lba;
      logic [16:0] left;
   } walk_type;
   walk_type cur, next_cur;
   always_comb begin
      next_cur = cur;
      if (load_in) begin
         next_cur.lba = lba_in;
         next_cur.left = (count_in == 16'h0000) ? 17'h10000 : {1'b0, count_in};
      end else if (step_in && cur.left != 17'h00000) begin
         next_cur.lba = cur.lba + 48'h000000000001;
         next_cur.left = cur.left - 17'h00001;
      end
   end
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cur <= '0;
      end else if (ce_in) begin
         cur <= next_cur;
      end
   end
   assign lba_out = cur.lba;
   assign left_out = cur.left;
endmodule

// ---- rtl/wmx_device.sv ----
// device end: decodes and executes the extended multi-sector writes
`timescale 1ns/1ns
`include "wmx_regs.svh"
module wmx_device
   import wmx_pkg::*;
#(
   parameter int WORDS_PER_SECTOR = 256,
   parameter int FLUSH_CYCLES = 64
) (
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   task_file_if.device TF,
   input wire logic [7:0] MULTIPLE_IN,
   input wire logic WCACHE_EN_IN,
   input wire logic MEDIA_READY_IN,
   input wire logic MEDIA_FAIL_IN,
   output logic [15:0] MEDIA_WORD_OUT,
   output logic MEDIA_WORD_VALID_OUT,
   output logic [47:0] MEDIA_LBA_OUT,
   output logic MEDIA_SECTOR_END_OUT
);
   typedef struct packed {
      dev_state_type state;
      logic [7:0] cnt_cur, cnt_prev, sn_cur, sn_prev, cl_cur, cl_prev, ch_cur, ch_prev;
      logic [7:0] status, error;
      logic fua;
      logic [15:0] words;
      logic [7:0] blk_secs;
      logic [15:0] flush_cnt;
      logic [47:0] err_lba;
      logic intrq;
      logic [15:0] rdata;
      logic [15:0] mword;
      logic mvalid;
      logic mend;
   } dev_reg_type;
   dev_reg_type r, next_r;
   logic [47:0] cur_lba;
   logic [16:0] left;
   logic load, step;
   localparam logic [15:0] LAST_WORD = 16'(WORDS_PER_SECTOR - 1);
   localparam logic [15:0] FLUSH_LAST = 16'(FLUSH_CYCLES - 1);
   // task-file write to one register address: a paired current/previous byte, the command or the data
   function automatic logic tf_wr(input logic [2:0] a, input logic wr, input logic [2:0] which);
      return wr && a == which;
   endfunction
   lba_walker u_lba_walker (
      .clk_in(CLK_SYS_IN),
      .rst_in(RST_IN),
      .ce_in(CE_IN),
      .load_in(load),
      .lba_in({r.ch_prev, r.cl_prev, r.sn_prev, r.ch_cur, r.cl_cur, r.sn_cur}),
      .count_in({r.cnt_prev, r.cnt_cur}),
      .step_in(step),
      .lba_out(cur_lba),
      .left_out(left)
   );
   // command decode, data acceptance and completion sequencing
   always_comb begin
      next_r = r;
      load = 1'b0;
      step = 1'b0;
      next_r.mvalid = 1'b0;
      next_r.mend = 1'b0;
      if (TF.rd && TF.addr == `TF_CMDSTAT) begin
         next_r.intrq = 1'b0; // status read acknowledges the interrupt
      end
      if (r.state == DEV_IDLE || r.state == DEV_DONE) begin
         // writes push current byte into previous, as the 48-bit task file does
         if (tf_wr(TF.addr, TF.wr, `TF_SCOUNT)) begin
            next_r.cnt_prev = r.cnt_cur;
            next_r.cnt_cur = TF.wdata[7:0];
         end
         if (tf_wr(TF.addr, TF.wr, `TF_SNUM)) begin
            next_r.sn_prev = r.sn_cur;
            next_r.sn_cur = TF.wdata[7:0];
         end
         if (tf_wr(TF.addr, TF.wr, `TF_CYLLO)) begin
            next_r.cl_prev = r.cl_cur;
            next_r.cl_cur = TF.wdata[7:0];
         end
         if (tf_wr(TF.addr, TF.wr, `TF_CYLHI)) begin
            next_r.ch_prev = r.ch_cur;
            next_r.ch_cur = TF.wdata[7:0];
         end
         if (tf_wr(TF.addr, TF.wr, `TF_CMDSTAT)) begin
            next_r.error = 8'h00;
            next_r.words = 16'h0000;
            next_r.blk_secs = 8'h00;
            next_r.intrq = 1'b0;
            if (TF.wdata[7:0] == `CMD_WR_MULT_EXT) begin
               next_r.fua = 1'b0;
               load = 1'b1;
               next_r.state = DEV_XFER;
               next_r.status = 8'h00;
               next_r.status[`ST_RDY] = 1'b1;
               next_r.status[`ST_DRQ] = 1'b1;
            end else if (TF.wdata[7:0] == `CMD_WR_MULT_FUA_EXT) begin
               next_r.fua = 1'b1;
               load = 1'b1;
               next_r.state = DEV_XFER;
               next_r.status = 8'h00;
               next_r.status[`ST_RDY] = 1'b1;
               next_r.status[`ST_DRQ] = 1'b1;
            end else begin
               next_r.error[`ER_ABT] = 1'b1;
               next_r.status = `STATUS_IDLE;
               next_r.status[`ST_ERR] = 1'b1;
               next_r.intrq = 1'b1;
               next_r.state = DEV_DONE;
            end
         end
      end
      unique case (r.state)
         DEV_IDLE, DEV_DONE: begin
         end
         DEV_XFER: begin
            // failing sector ends the transfer with error
            if (MEDIA_FAIL_IN) begin
               next_r.err_lba = cur_lba;
               next_r.error[`ER_UNC] = 1'b1;
               next_r.status = `STATUS_IDLE;
               next_r.status[`ST_ERR] = 1'b1;
               next_r.intrq = 1'b1;
               next_r.state = DEV_DONE;
            end else if (tf_wr(TF.addr, TF.wr, `TF_DATA) && r.status[`ST_DRQ]) begin
               next_r.mword = TF.wdata;
               next_r.mvalid = 1'b1;
               next_r.words = r.words + 16'h0001;
               if (r.words == LAST_WORD) begin
                  next_r.words = 16'h0000;
                  next_r.mend = 1'b1;
                  step = 1'b1;
                  next_r.blk_secs = r.blk_secs + 8'h01;
                  // interrupt at block end; the last sector moves on to commit without one
                  if (left == 17'h00001) begin
                     next_r.status[`ST_DRQ] = 1'b0;
                     next_r.status[`ST_BSY] = 1'b1;
                     next_r.state = DEV_COMMIT;
                  end else if (r.blk_secs + 8'h01 >= MULTIPLE_IN) begin
                     next_r.blk_secs = 8'h00;
                     next_r.intrq = 1'b1;
                  end
               end
            end
         end
         DEV_COMMIT: begin
            if (MEDIA_READY_IN) begin
               next_r.flush_cnt = 16'h0000;
               next_r.state = (r.fua || !WCACHE_EN_IN) ? DEV_FLUSH : DEV_DONE;
               if (!(r.fua || !WCACHE_EN_IN)) begin
                  next_r.status = `STATUS_IDLE;
                  next_r.intrq = 1'b1;
               end
            end
         end
         DEV_FLUSH: begin
            // status held back until media write completes
            next_r.flush_cnt = r.flush_cnt + 16'h0001;
            if (MEDIA_FAIL_IN) begin
               next_r.err_lba = cur_lba;
               next_r.error[`ER_UNC] = 1'b1;
               next_r.status = `STATUS_IDLE;
               next_r.status[`ST_ERR] = 1'b1;
               next_r.intrq = 1'b1;
               next_r.state = DEV_DONE;
            end else if (r.flush_cnt == FLUSH_LAST && MEDIA_READY_IN) begin
               next_r.status = `STATUS_IDLE;
               next_r.intrq = 1'b1;
               next_r.state = DEV_DONE;
            end
         end
         default: begin
            next_r.state = DEV_IDLE;
         end
      endcase
      // read data registered, stands the cycle after the strobe
      next_r.rdata = 16'h0000;
      if (TF.rd) begin
         unique case (TF.addr)
            `TF_ERRFEAT: next_r.rdata = {8'h00, r.error};
            `TF_SCOUNT: next_r.rdata = {8'h00, TF.hob ? left[15:8] : left[7:0]};
            // error address bytes by high-order flag
            `TF_SNUM: next_r.rdata = {8'h00, TF.hob ? r.err_lba[31:24] : r.err_lba[7:0]};
            `TF_CYLLO: next_r.rdata = {8'h00, TF.hob ? r.err_lba[39:32] : r.err_lba[15:8]};
            `TF_CYLHI: next_r.rdata = {8'h00, TF.hob ? r.err_lba[47:40] : r.err_lba[23:16]};
            `TF_CMDSTAT: next_r.rdata = {8'h00, r.status};
            default: next_r.rdata = 16'h0000;
         endcase
      end
   end
   // state register, frozen while the clock enable is low
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         r <= '0;
         r.status <= `STATUS_IDLE;
      end else if (CE_IN) begin
         r <= next_r;
      end
   end
   assign TF.rdata = r.rdata;
   assign TF.intrq = r.intrq;
   assign MEDIA_WORD_OUT = r.mword;
   assign MEDIA_WORD_VALID_OUT = r.mvalid;
   assign MEDIA_LBA_OUT = cur_lba;
   assign MEDIA_SECTOR_END_OUT = r.mend;
endmodule

// ---- rtl/wmx_host.sv ----
// host end: issues extended multi-sector writes from software registers
`timescale 1ns/1ns
`include "wmx_regs.svh"
module wmx_host
   import wmx_pkg::*;
(
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   input wire logic [3:0] ADDR_IN,
   input wire logic [31:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [31:0] RDATA_OUT,
   output logic IRQ_OUT,
   task_file_if.host TF
);
   typedef struct packed {
      host_state_type state;
      logic fua;
      logic [15:0] count;
      logic [47:0] lba;
      logic [15:0] word;
      logic word_full;
      logic [3:0] step;
      logic fetch;
      logic [1:0] irq_stat, irq_mask;
      logic [7:0] tfstat;
      logic [47:0] err_lba;
      logic intrq_s1, intrq_s2, intrq_d;
      logic [2:0] addr;
      logic [15:0] wdata;
      logic wr, rd, hob;
      logic [31:0] rdata;
   } host_reg_type;
   host_reg_type r, next_r;
   logic intrq_rise;
   function automatic logic hit(input logic [3:0] a, input logic [3:0] which);
      return a == which;
   endfunction
   // interrupt line crosses in from the device through two flops
   assign intrq_rise = r.intrq_s2 && !r.intrq_d;
   // software register decode and task-file command sequencing
   always_comb begin
      next_r = r;
      next_r.intrq_s1 = TF.intrq;
      next_r.intrq_s2 = r.intrq_s1;
      next_r.intrq_d = r.intrq_s2;
      next_r.wr = 1'b0;
      next_r.rd = 1'b0;
      next_r.hob = 1'b0;
      next_r.rdata = 32'h00000000;
      if (WR_IN) begin
         if (hit(ADDR_IN, `HREG_COUNT)) next_r.count = WDATA_IN[15:0];
         if (hit(ADDR_IN, `HREG_LBA_LO)) next_r.lba[31:0] = WDATA_IN;
         if (hit(ADDR_IN, `HREG_LBA_HI)) next_r.lba[47:32] = WDATA_IN[15:0];
         if (hit(ADDR_IN, `HREG_IRQ_MASK)) next_r.irq_mask = WDATA_IN[1:0];
         if (hit(ADDR_IN, `HREG_IRQ_STAT)) next_r.irq_stat = r.irq_stat & ~WDATA_IN[1:0];
         if (hit(ADDR_IN, `HREG_WDATA) && !r.word_full) begin
            next_r.word = WDATA_IN[15:0];
            next_r.word_full = 1'b1;
         end
         if (hit(ADDR_IN, `HREG_CTRL) && WDATA_IN[0] && r.state == HST_IDLE) begin
            next_r.fua = WDATA_IN[1];
            next_r.step = 4'h0;
            next_r.fetch = 1'b0;
            next_r.word_full = 1'b0; // a word left by a cut command must not leak into this one
            next_r.state = HST_SETUP;
         end
      end
      if (RD_IN) begin
         unique case (ADDR_IN)
            `HREG_CTRL: next_r.rdata = {31'h0, r.fua};
            `HREG_STATUS: next_r.rdata = {28'h0, r.word_full, r.state};
            `HREG_IRQ_STAT: next_r.rdata = {30'h0, r.irq_stat};
            `HREG_IRQ_MASK: next_r.rdata = {30'h0, r.irq_mask};
            `HREG_COUNT: next_r.rdata = {16'h0, r.count};
            `HREG_ERRLBA_LO: next_r.rdata = r.err_lba[31:0];
            `HREG_ERRLBA_HI: next_r.rdata = {16'h0, r.err_lba[47:32]};
            `HREG_TFSTAT: next_r.rdata = {24'h0, r.tfstat};
            default: next_r.rdata = 32'h00000000;
         endcase
      end
      unique case (r.state)
         HST_IDLE: begin
         end
         HST_SETUP: begin
            // previous byte first, then current byte, per register
            next_r.wr = 1'b1;
            next_r.step = r.step + 4'h1;
            unique case (r.step)
               4'h0, 4'h1: next_r.addr = `TF_SCOUNT;
               4'h2, 4'h3: next_r.addr = `TF_SNUM;
               4'h4, 4'h5: next_r.addr = `TF_CYLLO;
               4'h6, 4'h7: next_r.addr = `TF_CYLHI;
               default: begin
                  next_r.addr = `TF_CMDSTAT;
                  next_r.state = HST_DATA;
               end
            endcase
            unique case (r.step)
               4'h0: next_r.wdata = {8'h00, r.count[15:8]};
               4'h1: next_r.wdata = {8'h00, r.count[7:0]};
               4'h2: next_r.wdata = {8'h00, r.lba[31:24]};
               4'h3: next_r.wdata = {8'h00, r.lba[7:0]};
               4'h4: next_r.wdata = {8'h00, r.lba[39:32]};
               4'h5: next_r.wdata = {8'h00, r.lba[15:8]};
               4'h6: next_r.wdata = {8'h00, r.lba[47:40]};
               4'h7: next_r.wdata = {8'h00, r.lba[23:16]};
               default: next_r.wdata = {8'h00, r.fua ? `CMD_WR_MULT_FUA_EXT : `CMD_WR_MULT_EXT};
            endcase
         end
         HST_DATA: begin
            if (r.word_full) begin
               next_r.addr = `TF_DATA;
               next_r.wdata = r.word;
               next_r.wr = 1'b1;
               next_r.word_full = 1'b0;
            end
            if (intrq_rise) begin
               next_r.state = HST_POLL;
            end
         end
         HST_POLL: begin
            next_r.addr = `TF_CMDSTAT;
            next_r.rd = 1'b1;
            next_r.state = HST_READ;
            // error address read back, low bytes then upper bytes
            if (r.fetch) begin
               next_r.hob = r.step >= 4'h3;
               unique case (r.step)
                  4'h0, 4'h3: next_r.addr = `TF_SNUM;
                  4'h1, 4'h4: next_r.addr = `TF_CYLLO;
                  default: next_r.addr = `TF_CYLHI;
               endcase
            end
         end
         HST_READ: begin
            if (!r.rd && r.fetch) begin
               next_r.step = r.step + 4'h1;
               next_r.state = HST_POLL;
               unique case (r.step)
                  4'h0: next_r.err_lba[7:0] = TF.rdata[7:0];
                  4'h1: next_r.err_lba[15:8] = TF.rdata[7:0];
                  4'h2: next_r.err_lba[23:16] = TF.rdata[7:0];
                  4'h3: next_r.err_lba[31:24] = TF.rdata[7:0];
                  4'h4: next_r.err_lba[39:32] = TF.rdata[7:0];
                  default: begin
                     next_r.err_lba[47:40] = TF.rdata[7:0];
                     next_r.fetch = 1'b0;
                     next_r.irq_stat[`IRQ_DONE] = 1'b1;
                     next_r.state = HST_IDLE;
                  end
               endcase
            end else if (!r.rd) begin
               next_r.tfstat = TF.rdata[7:0];
               next_r.state = HST_WAIT;
               // block event only while more data is wanted
               if (TF.rdata[`ST_DRQ]) begin
                  next_r.irq_stat[`IRQ_BLOCK] = 1'b1;
                  next_r.state = HST_DATA;
               end else if (!TF.rdata[`ST_BSY] && TF.rdata[`ST_ERR]) begin
                  next_r.step = 4'h0;
                  next_r.fetch = 1'b1;
                  next_r.state = HST_POLL;
               end else if (!TF.rdata[`ST_BSY]) begin
                  next_r.irq_stat[`IRQ_DONE] = 1'b1;
                  next_r.state = HST_IDLE;
               end
            end
         end
         HST_WAIT: begin
            if (intrq_rise) next_r.state = HST_POLL;
         end
         default: next_r.state = HST_IDLE;
      endcase
   end
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         r <= '0;
      end else if (CE_IN) begin
         r <= next_r;
      end
   end
   assign TF.addr = r.addr;
   assign TF.wdata = r.wdata;
   assign TF.wr = r.wr;
   assign TF.rd = r.rd;
   assign TF.hob = r.hob;
   assign RDATA_OUT = r.rdata;
   assign IRQ_OUT = |(r.irq_stat & r.irq_mask);
endmodule

// ---- testbench/wmx_link_sva.sv ----
// link checker for the task-file interface between host and device ends
`timescale 1ns/1ns
`include "wmx_regs.svh"
module wmx_link_sva #(
   parameter int WORDS_PER_SECTOR = 4,
   parameter int BLOCK_SECTORS = 2
) (
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   input wire logic [2:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic intrq
);
   logic cmd_seen;
   logic [15:0] words;
   wire logic cmd_wr = wr && addr == `TF_CMDSTAT;
   wire logic ack = rd && addr == `TF_CMDSTAT && intrq;
   // words since the last acknowledged interrupt; the status read starts a new block
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cmd_seen <= 1'b0;
         words <= 16'h0000;
      end else begin
         cmd_seen <= cmd_seen | cmd_wr;
         if (ack)
            words <= 16'h0000;
         else if (wr && addr == `TF_DATA)
            words <= words + 16'h0001;
      end
   end
   default clocking cb @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);
   // setup walk: previous byte then current byte of each register
   sequence count_pair;
      (wr && addr == `TF_SCOUNT) [*2];
   endsequence
   sequence lba_bytes;
      (wr && addr == `TF_SNUM) [*2] ##1 (wr && addr == `TF_CYLLO) [*2] ##1 (wr && addr == `TF_CYLHI) [*2];
   endsequence
   a_lba_walk: assert property (count_pair |=> lba_bytes)
      else $error("address bytes did not follow the count pair");
   a_cmd_follows: assert property (lba_bytes |=> cmd_wr)
      else $error("command did not follow the address bytes");
   a_cmd_code: assert property (cmd_wr |-> wdata[7:0] inside {`CMD_WR_MULT_EXT, `CMD_WR_MULT_FUA_EXT})
      else $error("unexpected command code");
   a_data_after_cmd: assert property (wr && addr == `TF_DATA |-> cmd_seen)
      else $error("data word before any command");
   a_quiet_idle: assert property (!cmd_seen |-> !intrq)
      else $error("interrupt without a command");
   a_irq_holds: assert property (intrq && !ack |=> intrq)
      else $error("interrupt dropped before status read");
   a_irq_ack: assert property (ack |=> !intrq)
      else $error("interrupt kept after status read");
   a_block_words: assert property (words <= 16'(WORDS_PER_SECTOR * BLOCK_SECTORS))
      else $error("more words than one block without interrupt");
endmodule

// ---- testbench/ata_write_multiple_ext_tb.sv ----
// self-checking bench joining the host and device ends
`timescale 1ns/1ns
`include "wmx_regs.svh"
module ata_write_multiple_ext_tb;
   localparam int WPS = 4;
   localparam int FLUSH = 4;
   logic clk, rst, wr, rd, irq, wvalid, send;
   logic fail = 1'b0;
   logic wcache = 1'b0;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [15:0] mword;
   logic [47:0] mlba, first_lba;
   int fails, checks_done, words, base, sectors, fail_at, cyc, last_word, last_irq;
   task_file_if tf ();
   wmx_host u_wmx_host (.CLK_SYS_IN(clk), .RST_IN(rst), .CE_IN(1'b1), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .IRQ_OUT(irq), .TF(tf.host));
   wmx_device #(.WORDS_PER_SECTOR(WPS), .FLUSH_CYCLES(FLUSH)) u_wmx_device (.CLK_SYS_IN(clk), .RST_IN(rst),
      .CE_IN(1'b1), .TF(tf.device), .MULTIPLE_IN(8'h02), .WCACHE_EN_IN(wcache), .MEDIA_READY_IN(1'b1),
      .MEDIA_FAIL_IN(fail), .MEDIA_WORD_OUT(mword), .MEDIA_WORD_VALID_OUT(wvalid), .MEDIA_LBA_OUT(mlba),
      .MEDIA_SECTOR_END_OUT(send));
   wmx_link_sva #(.WORDS_PER_SECTOR(WPS), .BLOCK_SECTORS(2)) u_wmx_link_sva (.CLK_SYS_IN(clk), .RST_IN(rst),
      .addr(tf.addr), .wdata(tf.wdata), .wr(tf.wr), .rd(tf.rd), .intrq(tf.intrq));
   // clock generator
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // media side, sampled on the falling edge so registered outputs have settled
   always @(negedge clk) begin
      cyc <= cyc + 1;
      if (tf.intrq === 1'b1 && last_irq < last_word)
         last_irq <= cyc;
      if (wvalid === 1'b1) begin
         chk(48'(mword), 48'(16'h1000 + 16'(words - base))); // word order
         if (words == base)
            first_lba <= mlba;
         words <= words + 1;
         last_word <= cyc;
      end
      if (send === 1'b1)
         sectors <= sectors + 1;
   end
   // media fault raised on a rising edge once the cued sector has passed
   always @(posedge clk) begin
      fail <= fail_at != 0 && sectors >= fail_at;
   end
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // polls the sticky status; a bounded poll keeps a lost event from hanging the run
   task automatic wait_stat(input logic [31:0] m, output logic [31:0] v);
      for (int i = 0; i < 500; i++) begin
         rd_reg(`HREG_IRQ_STAT, v);
         if ((v & m) != 0)
            return;
      end
      chk(48'(v & m), 48'(m)); // event seen
   endtask
   // one command: nsec sectors of words, each block acknowledged in turn
   task automatic run_cmd(input logic [31:0] ctrl, input logic [15:0] cnt, input logic [47:0] lba, input int nsec);
      logic [31:0] v;
      base = words;
      wr_reg(`HREG_IRQ_STAT, 32'h3);
      wr_reg(`HREG_COUNT, {16'h0000, cnt});
      wr_reg(`HREG_LBA_LO, lba[31:0]);
      wr_reg(`HREG_LBA_HI, {16'h0000, lba[47:32]});
      wr_reg(`HREG_CTRL, ctrl);
      repeat (40) @(posedge clk);
      for (int s = 0; s < nsec; s++) begin
         for (int w = 0; w < WPS; w++) begin
            wr_reg(`HREG_WDATA, 32'h1000 + 32'(s * WPS + w));
            repeat (6) @(posedge clk);
         end
         if (s % 2 == 0 && s + 1 < nsec) begin
            rd_reg(`HREG_IRQ_STAT, v);
            chk(48'(v[0]), 48'h0); // no sector interrupt
         end else begin
            wait_stat(32'h3, v);
            wr_reg(`HREG_IRQ_STAT, 32'h1);
         end
      end
   endtask
   task automatic t_reset;
      logic [31:0] v;
      rd_reg(`HREG_IRQ_STAT, v);
      chk(48'(v), 48'h0); // status clear
      chk(48'(irq), 48'h0); // line low
      $display("test reset done");
   endtask
   task automatic t_plain;
      logic [31:0] v;
      run_cmd(32'h1, 16'h0103, 48'h123456789ABC, 259);
      wait_stat(32'h2, v);
      chk(48'(words - base), 48'h40C); // full count
      chk(first_lba, 48'h123456789ABC); // start address
      rd_reg(`HREG_TFSTAT, v);
      chk(48'(v[7:0]), 48'h50); // clean end
      $display("test plain write done");
   endtask
   task automatic t_irq;
      logic [31:0] v;
      wr_reg(`HREG_IRQ_MASK, 32'h0);
      #1 chk(48'(irq), 48'h0); // masked
      wr_reg(`HREG_IRQ_MASK, 32'h3);
      #1 chk(48'(irq), 48'h1); // unmasked
      wr_reg(`HREG_IRQ_STAT, 32'h3);
      #1 chk(48'(irq), 48'h0); // cleared
      rd_reg(`HREG_IRQ_STAT, v);
      chk(48'(v), 48'h0); // write one clears
      $display("test interrupt done");
   endtask
   task automatic t_fua;
      logic [31:0] v;
      @(posedge clk) wcache <= 1'b1;
      run_cmd(32'h3, 16'h0003, 48'h00000000FFFE, 3);
      wait_stat(32'h2, v);
      chk(48'(words - base), 48'hC); // all sectors
      chk(48'(last_irq - last_word >= FLUSH), 48'h1); // flush before status
      $display("test forced write done");
   endtask
   task automatic t_error;
      logic [31:0] v;
      fail_at = sectors + 1;
      run_cmd(32'h1, 16'h0003, 48'hF1E2D3C4B5A6, 2);
      wait_stat(32'h2, v);
      rd_reg(`HREG_ERRLBA_LO, v);
      chk(48'(v), 48'hD3C4B5A7); // low bytes
      rd_reg(`HREG_ERRLBA_HI, v);
      chk(48'(v[15:0]), 48'hF1E2); // upper bytes
      rd_reg(`HREG_TFSTAT, v);
      chk(48'(v[0]), 48'h1); // error bit
      fail_at = 0;
      $display("test media error done");
   endtask
   task automatic t_zero;
      logic [31:0] v;
      run_cmd(32'h1, 16'h0000, 48'h0, 2);
      rd_reg(`HREG_IRQ_STAT, v);
      chk(48'(v[1]), 48'h0); // still running
      chk(48'(words - base), 48'h8); // block passed
      @(posedge clk) rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd_reg(`HREG_IRQ_STAT, v);
      chk(48'(v), 48'h0); // cleared by reset
      $display("test zero count done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // watchdog sized well above the longest command sequence
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      wrap_up;
   end
   // main sequence
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h00000000;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_plain;
      t_irq;
      t_fua;
      t_error;
      t_zero;
      wrap_up;
   end
endmodule
